/* rtl/rcrf_defines.vh */
`ifndef RCRF_DEFINES_VH
`define RCRF_DEFINES_VH

// Frame layout.
`define RCRF_START_DELIM 8'h7E
`define RCRF_TYPE_REQ 8'h17
`define RCRF_TYPE_RSP 8'h97
`define RCRF_OFS_LEN 16'h0001
`define RCRF_OFS_TYPE 16'h0003
`define RCRF_OFS_FID 16'h0004
`define RCRF_OFS_DEST 16'h0005
`define RCRF_OFS_DEST_END 16'h000C
`define RCRF_OFS_OPT 16'h000F
`define RCRF_OFS_CMD_HI 16'h0010
`define RCRF_OFS_CMD_LO 16'h0011
`define RCRF_OFS_PARAM 16'h0012
`define RCRF_MIN_LEN 16'h000F
`define RCRF_CSUM_GOOD 8'hFF

// Option bits.
`define RCRF_OPT_NOACK 0
`define RCRF_OPT_APPLY 1
`define RCRF_OPT_SECURE 4

// Commit command, two ASCII characters.
`define RCRF_CMD_COMMIT 16'h4143

// Register offsets.
`define RCRF_REG_CTRL 4'h0
`define RCRF_REG_STATUS 4'h4
`define RCRF_REG_GOOD_CNT 4'h8
`define RCRF_REG_BAD_CNT 4'hC

// Control fields and reset values.
`define RCRF_CTRL_EN 0
`define RCRF_CTRL_SEC_CHK 1
`define RCRF_CTRL_RESET 2'h3

`endif

/* rtl/rcrf_fifo.v */
`timescale 1ns/1ps
module rcrf_fifo #(
  parameter W = 8,
  parameter D = 4,
  parameter AW = 2
) (
  // Clock and reset.
  input wire mclk,
  input wire arst_n,
  // Filling side.
  input wire in_valid,
  input wire [W-1:0] in_data,
  output reg in_ready,
  // Draining side.
  output wire out_valid,
  output wire [W-1:0] out_data,
  input wire out_ready
);
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] cnt_r;
  reg [AW:0] cnt_nxt;
  wire push;
  wire pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rd_ptr_r];

  // Occupancy after this cycle's push and pop.
  always @* begin
    cnt_nxt = cnt_r;
    if (push & ~pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop & ~push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == D - 1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == D - 1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != D);
    end
  end
endmodule // rcrf_fifo

/* rtl/rcrf_mem.v */
`timescale 1ns/1ps
module rcrf_mem #(
  parameter W = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock.
  input wire mclk,
  // Write port.
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [W-1:0] wr_data,
  // Registered read port.
  input wire [AW-1:0] rd_addr,
  output reg [W-1:0] rd_data
);
  reg [W-1:0] mem_r [0:DEPTH-1];

  always @(posedge mclk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data <= mem_r[rd_addr];
  end
endmodule // rcrf_mem

/* rtl/rcrf_rx.v */
// Functional notes
// (R1) Host puts type 0x17 at offset three.
// (R2) Length counts bytes between length and checksum.
// (R3) Frame identifier zero suppresses any response.
// (R4) Response carries the request's frame identifier.
// (R5) Host fills destination, all ones for short.
// (R6) Option bit zero disables acknowledgement; the code still raises rsp_valid and only passes the bit out on req_opt_noack.
// (R7) Option bit one applies change immediately.
// (R8) Without apply, change waits for commit.
// (R9) Option bit four needs secure session.
// (R10) Host writes zero to unused option bits.
// (R11) Command is two ASCII bytes at sixteen.
// (R12) Parameter bytes from eighteen mean a write.
// (R13) No parameter bytes means a query.
// (R14) Checksum is 0xFF minus summed body bytes.
// (R15) Host should send requests only as unicast.
// (R16) Host fills offsets thirteen, fourteen with 0xFFFE.
// (R17) Bad checksum frames are silently discarded.
`timescale 1ns/1ps
`include "rcrf_defines.vh"
module rcrf_rx #(
  parameter PDEPTH = 32,
  parameter PAW = 5,
  parameter FDEPTH = 4
) (
  // Clock and reset.
  input wire mclk,
  input wire arst_n,
  // Incoming byte stream from the host.
  input wire in_valid,
  input wire [7:0] in_data,
  output wire in_ready,
  // Secure session state.
  input wire session_up,
  // Decoded request.
  output reg req_valid,
  input wire req_ready,
  output reg [7:0] req_frame_id,
  output reg [63:0] req_dest,
  output reg [15:0] req_cmd,
  output reg req_opt_noack,
  output reg req_opt_apply,
  output reg req_opt_secure,
  output reg req_is_query,
  output reg [PAW:0] req_param_len,
  // Parameter read-out.
  input wire [PAW-1:0] param_addr,
  output wire [7:0] param_data,
  // Commit of pending settings.
  output reg apply_pulse,
  output reg pending,
  // Response trigger.
  output reg rsp_valid,
  output reg [7:0] rsp_type,
  output reg [7:0] rsp_frame_id,
  output reg rsp_err,
  // Register port.
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata
);
  localparam S_IDLE = 5'b00001;
  localparam S_LEN_H = 5'b00010;
  localparam S_LEN_L = 5'b00100;
  localparam S_BODY = 5'b01000;
  localparam S_CSUM = 5'b10000;

  reg [4:0] state_r;
  reg [15:0] len_r;
  reg [15:0] pos_r;
  reg [7:0] sum_r;
  reg [7:0] type_r;
  reg [7:0] fid_r;
  reg [63:0] dest_r;
  reg [7:0] opt_r;
  reg [15:0] cmd_r;
  reg [PAW:0] plen_r;
  reg ovf_r;
  reg [1:0] ctrl_r;
  reg [15:0] good_cnt_r;
  reg [15:0] bad_cnt_r;
  reg [31:0] rd_mux;
  wire [7:0] byte_in;
  wire byte_vld;
  wire take;
  wire [15:0] last_pos;
  wire [7:0] csum_total;
  wire frame_ok;
  wire sec_bad;
  wire accept;
  wire good_inc;
  wire bad_inc;
  wire is_query;
  wire commit_cmd;
  wire mem_wr;

  function [7:0] add8;
    input [7:0] a;
    input [7:0] b;
    begin
      add8 = a + b;
    end
  endfunction

  // Parser stalls while a decoded request waits, backing up the FIFO.
  assign take = ~req_valid;
  assign last_pos = len_r + 16'h0002; // (R2)
  assign csum_total = add8(sum_r, byte_in); // (R14)
  assign frame_ok = (csum_total == `RCRF_CSUM_GOOD) &&
                    (type_r == `RCRF_TYPE_REQ) &&
                    (len_r >= `RCRF_MIN_LEN) && ~ovf_r &&
                    ctrl_r[`RCRF_CTRL_EN]; // (R14) (R17)
  assign sec_bad = opt_r[`RCRF_OPT_SECURE] & ~session_up &
                   ctrl_r[`RCRF_CTRL_SEC_CHK]; // (R9)
  assign is_query = (plen_r == {(PAW+1){1'b0}}); // (R13)
  assign commit_cmd = (cmd_r == `RCRF_CMD_COMMIT);
  assign accept = (state_r == S_CSUM) && byte_vld && frame_ok;
  assign good_inc = accept && ~sec_bad;
  assign bad_inc = (state_r == S_CSUM) && byte_vld && ~frame_ok;
  assign mem_wr = (state_r == S_BODY) && byte_vld &&
                  (pos_r >= `RCRF_OFS_PARAM) &&
                  (pos_r < `RCRF_OFS_PARAM + PDEPTH); // (R12)

  rcrf_fifo #(
    .W(8),
    .D(FDEPTH),
    .AW(2)
  ) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(in_valid),
    .in_data(in_data),
    .in_ready(in_ready),
    .out_valid(byte_vld),
    .out_data(byte_in),
    .out_ready(take)
  );

  rcrf_mem #(
    .W(8),
    .DEPTH(PDEPTH),
    .AW(PAW)
  ) u_mem (
    .mclk(mclk),
    .wr_en(mem_wr & take),
    .wr_addr(plen_r[PAW-1:0]),
    .wr_data(byte_in),
    .rd_addr(param_addr),
    .rd_data(param_data)
  );

  // Byte parser.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_IDLE;
      len_r <= 16'h0000;
      pos_r <= 16'h0000;
      sum_r <= 8'h00;
      type_r <= 8'h00;
      fid_r <= 8'h00;
      dest_r <= 64'h0000_0000_0000_0000;
      opt_r <= 8'h00;
      cmd_r <= 16'h0000;
      plen_r <= {(PAW+1){1'b0}};
      ovf_r <= 1'b0;
    end else if (byte_vld && take) begin
      case (state_r)
        S_IDLE: begin
          if (byte_in == `RCRF_START_DELIM) begin
            state_r <= S_LEN_H;
          end
        end
        S_LEN_H: begin
          len_r <= {byte_in, 8'h00};
          state_r <= S_LEN_L;
        end
        S_LEN_L: begin
          len_r <= {len_r[15:8], byte_in};
          pos_r <= `RCRF_OFS_TYPE;
          sum_r <= 8'h00;
          type_r <= 8'h00;
          plen_r <= {(PAW+1){1'b0}};
          ovf_r <= 1'b0;
          state_r <= ({len_r[15:8], byte_in} == 16'h0000) ? S_CSUM : S_BODY;
        end
        S_BODY: begin
          sum_r <= add8(sum_r, byte_in); // (R14)
          pos_r <= pos_r + 16'h0001;
          if (pos_r == `RCRF_OFS_TYPE) begin
            type_r <= byte_in; // (R1)
          end
          if (pos_r == `RCRF_OFS_FID) begin
            fid_r <= byte_in; // (R3)
          end
          if ((pos_r >= `RCRF_OFS_DEST) && (pos_r <= `RCRF_OFS_DEST_END)) begin
            dest_r <= {dest_r[55:0], byte_in}; // (R5)
          end
          if (pos_r == `RCRF_OFS_OPT) begin
            opt_r <= byte_in; // (R6) (R7) (R9)
          end
          if (pos_r == `RCRF_OFS_CMD_HI) begin
            cmd_r <= {byte_in, 8'h00}; // (R11)
          end
          if (pos_r == `RCRF_OFS_CMD_LO) begin
            cmd_r <= {cmd_r[15:8], byte_in}; // (R11)
          end
          if (mem_wr) begin
            plen_r <= plen_r + 1'b1; // (R12)
          end else if (pos_r >= `RCRF_OFS_PARAM) begin
            ovf_r <= 1'b1;
          end
          if (pos_r == last_pos) begin
            state_r <= S_CSUM; // (R2)
          end
        end
        S_CSUM: begin
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // Request, commit and response outputs.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_valid <= 1'b0;
      req_frame_id <= 8'h00;
      req_dest <= 64'h0000_0000_0000_0000;
      req_cmd <= 16'h0000;
      req_opt_noack <= 1'b0;
      req_opt_apply <= 1'b0;
      req_opt_secure <= 1'b0;
      req_is_query <= 1'b0;
      req_param_len <= {(PAW+1){1'b0}};
      apply_pulse <= 1'b0;
      pending <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_type <= 8'h00;
      rsp_frame_id <= 8'h00;
      rsp_err <= 1'b0;
    end else begin
      apply_pulse <= 1'b0;
      rsp_valid <= 1'b0;
      if (req_valid && req_ready) begin
        req_valid <= 1'b0;
      end
      if (good_inc) begin
        req_valid <= 1'b1;
        req_frame_id <= fid_r;
        req_dest <= dest_r;
        req_cmd <= cmd_r;
        req_opt_noack <= opt_r[`RCRF_OPT_NOACK]; // (R6)
        req_opt_apply <= opt_r[`RCRF_OPT_APPLY]; // (R7)
        req_opt_secure <= opt_r[`RCRF_OPT_SECURE]; // (R9)
        req_is_query <= is_query; // (R13)
        req_param_len <= plen_r; // (R12)
        if (commit_cmd || (~is_query && opt_r[`RCRF_OPT_APPLY])) begin
          apply_pulse <= 1'b1; // (R7) (R8)
          pending <= 1'b0;
        end else if (~is_query) begin
          pending <= 1'b1; // (R8)
        end
      end
      if (accept && (fid_r != 8'h00)) begin
        rsp_valid <= 1'b1; // (R3)
        rsp_type <= `RCRF_TYPE_RSP;
        rsp_frame_id <= fid_r; // (R4)
        rsp_err <= sec_bad; // (R9)
      end
    end
  end

  // Register port with one-cycle read latency.
  always @* begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      `RCRF_REG_CTRL: rd_mux = {30'h0000_0000, ctrl_r};
      `RCRF_REG_STATUS: rd_mux = {29'h0000_0000, (state_r != S_IDLE),
                                  req_valid, pending};
      `RCRF_REG_GOOD_CNT: rd_mux = {16'h0000, good_cnt_r};
      `RCRF_REG_BAD_CNT: rd_mux = {16'h0000, bad_cnt_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `RCRF_CTRL_RESET;
      good_cnt_r <= 16'h0000;
      bad_cnt_r <= 16'h0000;
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      if (reg_wr && (reg_addr == `RCRF_REG_CTRL)) begin
        ctrl_r <= reg_wdata[1:0];
      end
      if (good_inc) begin
        good_cnt_r <= (reg_wr && (reg_addr == `RCRF_REG_GOOD_CNT)) ?
                      16'h0001 : good_cnt_r + 16'h0001;
      end else if (reg_wr && (reg_addr == `RCRF_REG_GOOD_CNT)) begin
        good_cnt_r <= 16'h0000;
      end
      if (bad_inc) begin
        bad_cnt_r <= (reg_wr && (reg_addr == `RCRF_REG_BAD_CNT)) ?
                     16'h0001 : bad_cnt_r + 16'h0001; // (R17)
      end else if (reg_wr && (reg_addr == `RCRF_REG_BAD_CNT)) begin
        bad_cnt_r <= 16'h0000;
      end
    end
  end
endmodule // rcrf_rx

/* verif/rcrf_host.sv */
`timescale 1ns/1ps
module rcrf_host (
  // Clock.
  input logic mclk,
  input logic arst_n,
  // Byte stream.
  output logic in_valid,
  output logic [7:0] in_data,
  input logic in_ready
);
  localparam logic [63:0] DEST = 64'h0013_A200_1234_5678;
  logic [7:0] q[$];
  bit slow = 0;
  bit go;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      in_valid <= 1'b0;
      in_data <= 8'h00;
    end else if (!in_valid || in_ready) begin
      if (in_valid) void'(q.pop_front());
      go = q.size() != 0 && (!slow || $urandom_range(1) == 0);
      in_valid <= go;
      in_data <= go ? q[0] : ~in_data;
    end
  end
  task automatic frame(input logic [7:0] fid, opt, input logic [15:0] cmd,
      input logic [7:0] p[$], input bit bad);
    logic [7:0] f[$];
    logic [7:0] s;
    f = {8'h17, fid};
    for (int i = 7; i >= 0; i--) f.push_back(DEST[i*8 +: 8]);
    f = {f, 8'hFF, 8'hFE, opt & 8'h13, cmd[15:8], cmd[7:0], p};
    s = 8'h00;
    foreach (f[i]) s += f[i];
    q = {q, 8'h7E, 8'h00, 8'(f.size()), f, (8'hFF - s) ^ {7'h00, bad}};
  endtask
endmodule // rcrf_host

/* verif/rcrf_rx_properties.sv */
`timescale 1ns/1ps
module rcrf_props #(
  parameter PAW = 5
) (
  // Clock.
  input logic mclk,
  input logic arst_n,
  // Request.
  input logic req_valid,
  input logic req_ready,
  input logic [7:0] req_frame_id,
  input logic [15:0] req_cmd,
  input logic req_opt_apply,
  input logic req_is_query,
  input logic [PAW:0] req_param_len,
  // Response.
  input logic apply_pulse,
  input logic pending,
  input logic rsp_valid,
  input logic [7:0] rsp_type,
  input logic [7:0] rsp_frame_id,
  input logic rsp_err
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  rsp_code_a: assert property (rsp_valid |-> rsp_type == 8'h97)
    else $error("bad response type");
  fid_silent_a: assert property (rsp_valid |-> rsp_frame_id != 8'h00)
    else $error("response for id zero");
  rsp_match_a: assert property (rsp_valid && !rsp_err |->
    req_valid && rsp_frame_id == req_frame_id)
    else $error("response id differs");
  secure_err_a: assert property (rsp_valid && rsp_err |-> !req_valid)
    else $error("refused request passed");
  query_len_a: assert property (req_valid |->
    req_is_query == (req_param_len == 0))
    else $error("query flag wrong");
  req_hold_a: assert property (req_valid && !req_ready |=>
    req_valid && $stable(req_cmd) && $stable(req_frame_id))
    else $error("request changed");
  apply_cause_a: assert property (apply_pulse |-> !pending &&
    req_valid && (req_opt_apply && !req_is_query || req_cmd == 16'h4143))
    else $error("apply without cause");
  pend_set_a: assert property ($rose(pending) |-> req_valid &&
    !req_opt_apply && !req_is_query)
    else $error("pending without change");
  cover property (rsp_valid && rsp_err);
  cover property (apply_pulse);
  cover property (req_valid && req_is_query);
endmodule // rcrf_props

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic mclk = 0;
  logic arst_n = 0;
  logic session_up = 1;
  logic req_ready = 0;
  logic [4:0] param_addr = 0;
  logic [3:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic in_valid, in_ready, req_valid, req_opt_noack, req_opt_apply;
  logic req_opt_secure, req_is_query, apply_pulse, pending, rsp_valid;
  logic rsp_err;
  logic [7:0] in_data, req_frame_id, param_data, rsp_type, rsp_frame_id;
  logic [63:0] req_dest;
  logic [15:0] req_cmd;
  logic [5:0] req_param_len;
  logic [31:0] reg_rdata;
  logic [8:0] got_q[$], exp_q[$];
  logic [7:0] p[$], p1[$];
  logic [7:0] f, o;
  int errors = 0, tests_run = 0, applies = 0, exp_app = 0;
  bit exp_pend = 0;
  always #5 mclk = ~mclk;
  rcrf_rx rcrf_rx_i (.*);
  rcrf_host rcrf_host_i (.*);
  always @(posedge mclk) begin
    if (rsp_valid) got_q.push_back({rsp_err, rsp_frame_id});
    if (apply_pulse) applies++;
  end
  task automatic chk(string nm, logic [63:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge mclk) reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge mclk) reg_wr <= 0;
  endtask
  task automatic rchk(string nm, logic [3:0] a, logic [31:0] e);
    @(posedge mclk) reg_addr <= a;
    reg_rd <= 1;
    @(posedge mclk) reg_rd <= 0;
    #1 chk(nm, reg_rdata, e);
  endtask
  task automatic send(logic [7:0] fid, opt, logic [15:0] cmd,
      logic [1:0] bad, bit err);
    rcrf_host_i.frame(fid, opt, cmd, p, bad[0]);
    if (bad == 0 && fid != 0) exp_q.push_back({err, fid});
    if (bad != 0 || err) return;
    if (cmd == 16'h4143 || p.size() != 0 && opt[1]) begin
      exp_app++;
      exp_pend = 0;
    end else if (p.size() != 0) exp_pend = 1;
  endtask
  task automatic take(logic [7:0] fid, opt, logic [15:0] cmd,
      logic [7:0] pp[$]);
    int n;
    logic [2:0] ob;
    n = 0;
    #1;
    while (req_valid !== 1'b1 && n < 2000) @(posedge mclk) #1 n++;
    ob = {req_opt_secure, req_opt_apply, req_opt_noack};
    chk("req_frame_id", req_frame_id, fid);
    chk("req_dest", req_dest, rcrf_host_i.DEST);
    chk("req_cmd", req_cmd, cmd);
    chk("opts", ob, {opt[4], opt[1:0]});
    chk("query", req_is_query, pp.size() == 0);
    chk("plen", req_param_len, pp.size());
    foreach (pp[k]) begin
      @(posedge mclk) param_addr <= 5'(k);
      @(posedge mclk) #1 chk("param", param_data, pp[k]);
    end
    @(posedge mclk) req_ready <= 1;
    @(posedge mclk) req_ready <= 0;
  endtask
  task automatic settle();
    int n;
    n = 0;
    while (rcrf_host_i.q.size() != 0 && n < 2000) @(posedge mclk) n++;
    repeat (8) @(posedge mclk);
    #1 chk("rsps", got_q.size(), exp_q.size());
    foreach (exp_q[i]) chk("rsp", got_q[i], exp_q[i]);
    chk("applies", applies, exp_app);
    chk("pending", pending, exp_pend);
    got_q = {};
    exp_q = {};
  endtask
  task automatic report_and_stop();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h3fd5));
    repeat (2) @(posedge mclk);
    arst_n <= 1;
    rchk("ctrl", 4'h0, 32'h0000_0003);
    rchk("status", 4'h4, 32'h0000_0000);
    rchk("unmapped", 4'h2, 32'h0000_0000);
    repeat (32) p.push_back(8'($urandom));
    send(8'h27, 8'h02, 16'h4E49, 0, 0);
    p1 = p;
    p = {};
    send(8'h00, 8'h01, 16'h5450, 0, 0);
    repeat (120) @(posedge mclk);
    #1 chk("in_ready", in_ready, 0);
    rchk("status", 4'h4, 32'h0000_0002);
    take(8'h27, 8'h02, 16'h4E49, p1);
    take(8'h00, 8'h01, 16'h5450, p);
    settle();
    rchk("good", 4'h8, 32'h0000_0002);
    p = {8'h04, 8'h51};
    send(8'h68, 8'h00, 16'h4944, 0, 0);
    take(8'h68, 8'h00, 16'h4944, p);
    settle();
    p = {};
    send(8'h41, 8'h00, 16'h4143, 0, 0);
    take(8'h41, 8'h00, 16'h4143, p);
    p = {8'h01};
    send(8'h55, 8'h13, 16'h4E49, 0, 0);
    take(8'h55, 8'h13, 16'h4E49, p);
    settle();
    send(8'h33, 8'h00, 16'h4E49, 1, 0);
    repeat (33) p.push_back(8'($urandom));
    send(8'h34, 8'h02, 16'h4E49, 2, 0);
    wr(4'h0, 32'h0000_0002);
    p = {};
    send(8'h35, 8'h02, 16'h4E49, 2, 0);
    settle();
    rchk("bad", 4'hC, 32'h0000_0003);
    wr(4'h0, 32'h0000_0003);
    @(posedge mclk) session_up <= 0;
    send(8'h5A, 8'h10, 16'h4E49, 0, 1);
    settle();
    @(posedge mclk) session_up <= 1;
    rcrf_host_i.slow = 1;
    repeat (6) begin
      f = 8'($urandom_range(255, 1));
      o = 8'($urandom) & 8'h13;
      p = {};
      repeat ($urandom_range(5)) p.push_back(8'($urandom));
      send(f, o, 16'h4E49, 0, 0);
      take(f, o, 16'h4E49, p);
      settle();
    end
    report_and_stop();
  end
endmodule // testbench
bind rcrf_rx rcrf_props #(.PAW(PAW)) rcrf_props_i (.*);
